// >>> core/lbps_pkg.sv
// Constants for the LCD bias power sequencer.
// Assumes a single 100 MHz clock with synchronous active-high reset.

package lbps_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned SRC_CHECK_US   = 1000;
  localparam int unsigned SRC_CHECK_CYC  =
    SRC_CHECK_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned TMR_W          = 24;
  localparam int unsigned SS_W           = 8;
  localparam int unsigned SS_STEP_CYC    = 1000;

  // ==========================================================
  // Reset values
  localparam logic [TMR_W-1:0] RST_TIME_DEF = 24'h00_0000;
  localparam logic [TMR_W-1:0] DLY_TIME_DEF = 24'h00_0000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF     = 3'b000,
    SEQ_WAIT_PG = 3'b001,
    SEQ_RST     = 3'b010,
    SEQ_DLY     = 3'b011,
    SEQ_CHECK   = 3'b100,
    SEQ_RUN     = 3'b101,
    SEQ_ERR     = 3'b110
  } lbps_state_t;

endpackage

// >>> core/lbps_seq.sv
// Top-level start-up sequencer for a four-rail LCD bias supply.
// Assumes analog status inputs are asynchronous pins; timing values
// are static configuration in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none

module lbps_seq #(
  parameter int unsigned TW          = lbps_pkg::TMR_W,
  parameter int unsigned CHECK_CYC   = lbps_pkg::SRC_CHECK_CYC,
  parameter int unsigned SS_STEP     = lbps_pkg::SS_STEP_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          srst,
  // Analog status pins
  input  wire logic          vin_above_uvlo,
  input  wire logic          buck_power_good,
  input  wire logic          over_temp,
  input  wire logic          source_near_vin,
  input  wire logic          pos_fb_at_sc_thresh,
  input  wire logic          ext_enable,
  input  wire logic          ext_enable_used,
  // Programmed durations
  input  wire logic [TW-1:0] reset_timing_pin,
  input  wire logic [TW-1:0] delay_timing_pin,
  // Supply controls
  output logic               buck_enable,
  output logic               neg_pump_enable,
  output logic               boost_enable,
  output logic               pos_pump_enable,
  output logic               pos_pump_sc_mode,
  output logic               positive_pump_control,
  output logic [lbps_pkg::SS_W-1:0] pos_pump_ss_level,
  output logic               isolation_gate_drive,
  output logic               panel_reset_n_o,
  output logic               panel_reset_n_oe,
  output logic               seq_error
);
  import lbps_pkg::*;

  // ==========================================================
  // Input synchronisation
  logic [5:0] pins_s;
  lbps_sync #(.W(6)) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({vin_above_uvlo, buck_power_good, over_temp,
                source_near_vin, pos_fb_at_sc_thresh, ext_enable}),
    .sync_out (pins_s)
  );

  wire uvlo_ok  = pins_s[5];
  wire pg_ok    = pins_s[4];
  wire hot      = pins_s[3];
  wire src_ok   = pins_s[2];
  wire fb_sc    = pins_s[1];
  wire en_s     = pins_s[0];

  // Over-temperature or UVLO drops everything at once
  wire shutdown = !uvlo_ok || hot;
  // Enable only gates when strapped in use
  wire gate_ok  = !ext_enable_used || en_s;

  // ==========================================================
  // State
  lbps_state_t state_reg, state_next;
  logic        rst_start, dly_start, rst_done, dly_done;
  logic [31:0] chk_cnt_reg;
  logic        sc_off_reg;
  logic [15:0] ss_div_reg;

  wire chk_done = (chk_cnt_reg >= CHECK_CYC - 1);
  wire ss_tick  = (ss_div_reg == 16'(SS_STEP - 1));

  // External enable replaces the reset timer when used
  wire rst_expired = ext_enable_used ? gate_ok : rst_done;

  lbps_timer #(.W(TW)) u_rst_tmr (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .clear    (shutdown),
    .start    (rst_start),
    .terminal (reset_timing_pin),
    .done     (rst_done)
  );

  lbps_timer #(.W(TW)) u_dly_tmr (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .clear    (shutdown),
    .start    (dly_start),
    .terminal (delay_timing_pin),
    .done     (dly_done)
  );

  // ==========================================================
  // Next-state decode
  always_comb begin
    state_next = state_reg;
    rst_start  = 1'b0;
    dly_start  = 1'b0;
    unique case (state_reg)
      SEQ_OFF: begin
        state_next = SEQ_WAIT_PG;
      end
      SEQ_WAIT_PG: begin
        if (pg_ok) begin
          state_next = SEQ_RST;
          rst_start  = 1'b1;
        end
      end
      SEQ_RST: begin
        if (rst_expired) begin
          state_next = SEQ_DLY;
          dly_start  = 1'b1;
        end
      end
      SEQ_DLY: begin
        if (dly_done) begin
          state_next = SEQ_CHECK;
        end
      end
      SEQ_CHECK: begin
        if (chk_done) begin
          state_next = src_ok ? SEQ_RUN : SEQ_ERR;
        end
      end
      SEQ_RUN: begin
        state_next = SEQ_RUN;
      end
      SEQ_ERR: begin
        state_next = SEQ_ERR;
      end
      default: begin
        state_next = SEQ_OFF;
      end
    endcase
  end

  // ==========================================================
  // Output decode
  // Codes rise with progress through the sequence; the spare
  // code never counts as reached
  function automatic logic reached(
    input lbps_state_t s,
    input lbps_state_t mark
  );
    reached = (s >= mark) && (s != 3'b111);
  endfunction

  wire past_rst  = reached(state_reg, SEQ_DLY);
  wire gate_on   = reached(state_reg, SEQ_CHECK);
  wire in_check  = (state_reg == SEQ_CHECK);
  wire in_err    = (state_reg == SEQ_ERR);
  wire running   = (state_reg == SEQ_RUN);
  wire awake     = (state_reg != SEQ_OFF);
  wire ss_full   = (pos_pump_ss_level == '1);

  // Reset release driven by internal sequence and, when used, ext_enable; pin level ignored
  wire rst_pull  = !past_rst;

  // ==========================================================
  // Next values of the supply controls
  wire buck_en_next  = awake;
  wire neg_en_next   = past_rst && gate_ok;
  wire boost_en_next = running;
  wire pos_en_next   = gate_on && !in_err;
  wire sc_mode_next  = in_check;
  // Pump current stays off in the check once feedback shows no short
  wire pump_ctl_next = running || (in_check && !sc_off_reg);
  wire gate_drv_next = !gate_on;
  // Open drain: the data bit stays low, only the enable moves
  wire rst_oe_next   = rst_pull || !gate_ok;
  wire err_next      = in_err;

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      state_reg <= SEQ_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown || state_reg != SEQ_CHECK) begin
      chk_cnt_reg <= '0;
    end else begin
      chk_cnt_reg <= chk_cnt_reg + 32'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown || state_reg != SEQ_CHECK) begin
      sc_off_reg <= 1'b0;
    end else if (fb_sc) begin
      sc_off_reg <= 1'b1;
    end
  end

  // Soft-start divider; a slow ramp trades start time for inrush
  always_ff @(posedge sys_clk) begin
    if (srst || !running || ss_tick) begin
      ss_div_reg <= '0;
    end else begin
      ss_div_reg <= ss_div_reg + 16'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown || !running) begin
      pos_pump_ss_level <= '0;
    end else if (ss_tick && !ss_full) begin
      pos_pump_ss_level <= pos_pump_ss_level + SS_W'(1);
    end
  end

  // ==========================================================
  // Output registers; every control drops at once on shutdown
  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      buck_enable <= 1'b0;
    end else begin
      buck_enable <= buck_en_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      neg_pump_enable <= 1'b0;
    end else begin
      neg_pump_enable <= neg_en_next;
    end
  end

  // Boost waits for the source check; early switching stresses the switch
  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      boost_enable <= 1'b0;
    end else begin
      boost_enable <= boost_en_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      pos_pump_enable <= 1'b0;
    end else begin
      pos_pump_enable <= pos_en_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      pos_pump_sc_mode <= 1'b0;
    end else begin
      pos_pump_sc_mode <= sc_mode_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      positive_pump_control <= 1'b0;
    end else begin
      positive_pump_control <= pump_ctl_next;
    end
  end

  // Active low: high keeps the isolation switch off
  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      isolation_gate_drive <= 1'b1;
    end else begin
      isolation_gate_drive <= gate_drv_next;
    end
  end

  // Never driven high; the pull-up supplies the released level
  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      panel_reset_n_o <= 1'b0;
    end else begin
      panel_reset_n_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      panel_reset_n_oe <= 1'b1;
    end else begin
      panel_reset_n_oe <= rst_oe_next;
    end
  end

  // Error holds until shutdown or reset clears the sequence
  always_ff @(posedge sys_clk) begin
    if (srst || shutdown) begin
      seq_error <= 1'b0;
    end else begin
      seq_error <= err_next;
    end
  end

endmodule

`default_nettype wire

// >>> core/lbps_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
// Assumes inputs come from pins outside the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none

module lbps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// >>> core/lbps_timer.sv
// Start/expire counter with programmable terminal count.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
`default_nettype none

module lbps_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         clear,
  input  wire logic         start,
  input  wire logic [W-1:0] terminal,
  output logic              done
);

  logic [W-1:0] cnt_reg;
  logic         run_reg;
  wire          at_end = (cnt_reg >= terminal);

  // Terminal zero expires one cycle after start
  always_ff @(posedge sys_clk) begin
    if (srst || clear) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      cnt_reg <= '0;
      run_reg <= 1'b1;
      done    <= 1'b0;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg + W'(1);
      run_reg <= !at_end;
      done    <= at_end;
    end else begin
      done    <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> verif/lbps_far.sv
// Far-side model: buck sense, source rail, feedback and reset pull-up.
// Assumes the bench steers source lag and a dead-rail fault.
`timescale 1ns/10ps
`default_nettype none
module lbps_far (
  input  wire logic       sys_clk,
  input  wire logic       buck_enable,
  input  wire logic       isolation_gate_drive,
  input  wire logic       pos_pump_sc_mode,
  input  wire logic       panel_reset_n_o,
  input  wire logic       panel_reset_n_oe,
  input  wire logic [7:0] src_lag,
  input  wire logic       src_dead,
  output logic            buck_power_good,
  output logic            source_near_vin,
  output logic            pos_fb_at_sc_thresh,
  output logic            panel_reset_n
);
  // ==========================================================
  // Analog stand-ins
  logic [7:0] gl_cnt;
  // Idle open-drain line floats up to the pull-up
  assign panel_reset_n = panel_reset_n_oe ? panel_reset_n_o : 1'b1;
  initial begin
    gl_cnt = 8'h00;
    buck_power_good = 1'b0;
    source_near_vin = 1'b0;
    pos_fb_at_sc_thresh = 1'b0;
  end
  always @(posedge sys_clk) begin
    buck_power_good <= buck_enable;
    gl_cnt <= isolation_gate_drive ? 8'h00 : gl_cnt + {7'h00, gl_cnt < 8'hff};
    source_near_vin <= !src_dead && !isolation_gate_drive && gl_cnt >= src_lag;
    pos_fb_at_sc_thresh <= pos_pump_sc_mode && gl_cnt > 8'h03;
  end
endmodule
`default_nettype wire

// >>> verif/lbps_seq_asserts.sv
// Ordering and timing checks on the sequencer's ports.
// Assumes binding to lbps_seq; srst disables every check.
`timescale 1ns/10ps
`default_nettype none
module lbps_seq_chk #(
  parameter int unsigned CHECK_CYC = lbps_pkg::SRC_CHECK_CYC
) (
  input wire logic                      sys_clk,
  input wire logic                      srst,
  input wire logic                      vin_above_uvlo,
  input wire logic                      over_temp,
  input wire logic                      pos_fb_at_sc_thresh,
  input wire logic                      ext_enable,
  input wire logic                      ext_enable_used,
  input wire logic                      buck_enable,
  input wire logic                      neg_pump_enable,
  input wire logic                      boost_enable,
  input wire logic                      pos_pump_sc_mode,
  input wire logic                      positive_pump_control,
  input wire logic [lbps_pkg::SS_W-1:0] pos_pump_ss_level,
  input wire logic                      isolation_gate_drive,
  input wire logic                      panel_reset_n_o,
  input wire logic                      panel_reset_n_oe,
  input wire logic                      seq_error
);
  // ==========================================================
  // Checks
  int unsigned gl_reg;
  always_ff @(posedge sys_clk) begin
    gl_reg <= (srst || isolation_gate_drive) ? 0 : gl_reg + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_rails_off: assert property (
    $fell(vin_above_uvlo) |-> ##6 !(buck_enable || neg_pump_enable))
    else $error("rails still on after undervoltage");
  chk_neg_order: assert property (
    neg_pump_enable |-> buck_enable) else $error("negative pump early");
  chk_release_pump: assert property (
    $fell(panel_reset_n_oe) |-> ##[0:1] neg_pump_enable)
    else $error("negative pump not enabled at release");
  chk_od_low: assert property (
    panel_reset_n_o == 1'b0) else $error("reset drives high");
  chk_sc_gate: assert property (
    $fell(isolation_gate_drive) |-> pos_pump_sc_mode)
    else $error("no short-circuit mode at gate low");
  chk_check_time: assert property (
    $rose(boost_enable) |-> gl_reg + 1 >= CHECK_CYC && gl_reg <= CHECK_CYC + 4)
    else $error("boost start off the check point");
  chk_err_boost: assert property (
    seq_error |-> !boost_enable) else $error("boost on with error");
  chk_sc_normal: assert property (
    $rose(boost_enable) |-> ##[0:2] !pos_pump_sc_mode)
    else $error("pump stuck in short-circuit mode");
  chk_ss_ramp: assert property (
    $changed(pos_pump_ss_level) |-> pos_pump_ss_level == 0 ||
    pos_pump_ss_level == $past(pos_pump_ss_level) + 1'b1)
    else $error("soft-start level stepped");
  chk_hot_off: assert property (
    $rose(over_temp) |-> ##5 !(buck_enable || boost_enable))
    else $error("rails still on when hot");
  chk_en_hold: assert property (
    ext_enable_used && !ext_enable && !$past(ext_enable) &&
    !$past(ext_enable, 2) && !$past(ext_enable, 3)
    |-> !neg_pump_enable && panel_reset_n_oe)
    else $error("enable low but reset released");
  chk_fb_cutoff: assert property (
    $rose(pos_fb_at_sc_thresh) && pos_pump_sc_mode
    |-> ##[1:5] !positive_pump_control)
    else $error("pump current not cut at threshold");
  cover property (ext_enable_used && $rose(boost_enable));
  cover property ($rose(boost_enable));
  cover property ($rose(seq_error));
  cover property ($fell(panel_reset_n_oe));
endmodule
bind lbps_seq lbps_seq_chk #(.CHECK_CYC(CHECK_CYC)) i_lbps_seq_chk (.*);
`default_nettype wire

// >>> verif/lbps_seq_test.sv
// Self-checking bench: power-up outcomes, faults, external enable.
// Assumes a short source check and soft-start step via parameters.
`timescale 1ns/10ps
`default_nettype none
module lbps_seq_test;
  import lbps_pkg::*;
  localparam int unsigned CHK = 20;
  // ==========================================================
  // Signals
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              vin_above_uvlo = 1'b0;
  logic              over_temp = 1'b0;
  logic              ext_enable = 1'b0;
  logic              ext_enable_used = 1'b0;
  logic              src_dead = 1'b0;
  logic [7:0]        src_lag = 8'h02;
  logic [23:0]       reset_timing_pin = 24'h00_0005;
  logic [23:0]       delay_timing_pin = 24'h00_0007;
  logic              buck_power_good, source_near_vin, pos_fb_at_sc_thresh;
  logic              buck_enable, neg_pump_enable, boost_enable;
  logic              pos_pump_enable, pos_pump_sc_mode, positive_pump_control;
  logic [SS_W-1:0]   pos_pump_ss_level;
  logic              isolation_gate_drive, seq_error, panel_reset_n;
  logic              panel_reset_n_o, panel_reset_n_oe, bo_d, er_d;
  logic [1:0]        exp_q[$];
  int                err_total = 0;
  int                n_checks = 0;
  int                seed = 32'hc4f1;
  int                gl = 0;
  lbps_seq #(.TW(24), .CHECK_CYC(CHK), .SS_STEP(2)) i_lbps_seq (.*);
  lbps_far i_lbps_far (.*);
  initial forever #5 sys_clk = ~sys_clk;
  // ==========================================================
  // Checking
  task automatic fail(input string msg);
    err_total++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) fail(msg);
  endtask
  task automatic cmp_evt(input logic [1:0] got, input int cyc);
    n_checks++;
    if (exp_q.size() == 0) fail("unexpected outcome");
    else if (got !== exp_q.pop_front() || cyc + 1 < CHK || cyc > CHK + 4)
      fail("outcome or check time wrong");
  endtask
  // Outcome is judged where it appears, not where it was requested
  always @(posedge sys_clk) begin
    gl <= isolation_gate_drive ? 0 : gl + 1;
    if (!srst && ((boost_enable && !bo_d) || (seq_error && !er_d)))
      cmp_evt({seq_error, boost_enable}, gl);
    bo_d <= boost_enable;
    er_d <= seq_error;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 600) begin
      cyc(1);
      k++;
    end
    if (exp_q.size() != 0) fail("no outcome");
  endtask
  task automatic power_up(input logic [1:0] code);
    exp_q.push_back(code);
    cyc(1);
    vin_above_uvlo <= 1'b1;
    wait_done;
  endtask
  task automatic power_down(input string name);
    cyc(1);
    vin_above_uvlo <= 1'b0;
    cyc(8);
    cmp_bit(buck_enable | neg_pump_enable | boost_enable, 1'b0, "rails on");
    cyc(4);
    $display("test %s done", name);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(20000);
    fail("watchdog");
    complete_run;
  end
  // ==========================================================
  // Scenarios
  initial begin
    cyc(6);
    srst <= 1'b0;
    power_up(2'b01);
    cyc(6);
    cmp_bit(pos_pump_enable, 1'b1, "pos pump off");
    cmp_bit(positive_pump_control, 1'b1, "pump current off");
    cmp_bit(pos_pump_sc_mode, 1'b0, "still short mode");
    cmp_bit(isolation_gate_drive, 1'b0, "gate off");
    cmp_bit(pos_pump_ss_level != '0, 1'b1, "no soft start");
    power_down("normal");
    src_dead <= 1'b1;
    power_up(2'b10);
    cmp_bit(pos_pump_enable | positive_pump_control, 1'b0, "pump on");
    power_down("dead source");
    src_dead <= 1'b0;
    reset_timing_pin <= 24'h00_0000;
    power_up(2'b01);
    power_down("zero reset");
    repeat (3) begin
      reset_timing_pin <= 24'($random(seed)) & 24'h00_001f;
      delay_timing_pin <= 24'($random(seed)) & 24'h00_001f;
      src_lag <= 8'($random(seed)) & 8'h07;
      power_up(2'b01);
      power_down("random timing");
    end
    power_up(2'b01);
    over_temp <= 1'b1;
    cyc(8);
    cmp_bit(buck_enable | boost_enable, 1'b0, "hot rails on");
    exp_q.push_back(2'b01);
    over_temp <= 1'b0;
    wait_done;
    power_down("over temperature");
    ext_enable_used <= 1'b1;
    cyc(1);
    vin_above_uvlo <= 1'b1;
    cyc(30);
    cmp_bit(buck_enable, 1'b1, "buck off");
    cmp_bit(neg_pump_enable, 1'b0, "pump on");
    cmp_bit(panel_reset_n, 1'b0, "reset released");
    exp_q.push_back(2'b01);
    ext_enable <= 1'b1;
    wait_done;
    cmp_bit(panel_reset_n, 1'b1, "reset held");
    power_down("external enable");
    complete_run;
  end
endmodule
`default_nettype wire
